// >>> hw/rsq_reset_source.sv
// reset source sequencer: flash, software and usb causes, cause flags
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
module rsq_reset_source import rsq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rsq_flash_req_s flash_req,
  input wire logic flash_write_enable,
  input wire logic vdd_mon_en,
  input wire logic vdd_ok_pin,
  input wire logic clock_loss_pin,
  input wire logic cmp0_pin,
  input wire logic wdt_timeout,
  input wire logic usb_ctrl_enabled,
  input wire logic usb_bus_reset,
  input wire logic vbus_pin,
  input wire logic vbus_polarity_select,
  input wire logic rst_pin_in_n,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  output logic sys_rst_n,
  output logic irq
);
  rsq_state_e state;
  rsq_state_e next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] cause;
  logic [7:0] next_cause;
  logic [7:0] raw;
  logic [7:0] flags;
  logic [7:0] ist;
  logic [7:0] imk;
  logic [4:0] sync_q;
  logic usb_en;
  logic cmp_en;
  logic mcd_en;
  logic vdd_sel;
  logic flash_err;
  logic hit;
  logic wr_rcr;
  logic wr_ist;
  logic wr_imk;
  logic sw_req;
  logic soft_por;
  logic exit_go;
  logic usb_bus_hit;
  logic vbus_hit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pin-level inputs into the clock domain
  rsq_sync #(
    .W(5),
    .RST(SYNC_RST)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({vbus_pin, cmp0_pin, clock_loss_pin, vdd_ok_pin, rst_pin_in_n}),
    .dout(sync_q)
  );

  // illegal flash access detector
  rsq_flash_chk u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .flash_req(flash_req),
    .flash_write_enable(flash_write_enable),
    .vdd_mon_en(vdd_mon_en),
    .flash_err(flash_err)
  );

  // apb decode; every access completes with no wait state
  assign hit = (paddr == RCR_ADDR) || (paddr == IST_ADDR) ||
               (paddr == IMK_ADDR);
  assign wr_rcr = psel && penable && pwrite && (paddr == RCR_ADDR);
  assign wr_ist = psel && penable && pwrite && (paddr == IST_ADDR);
  assign wr_imk = psel && penable && pwrite && (paddr == IMK_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // write-side strobes of the cause register
  assign sw_req = wr_rcr && pwdata[B_SW];
  assign soft_por = wr_rcr && pwdata[B_PIN];

  // usb conditions; the bus reset is gated by the controller being on, the vbus match is not
  assign usb_bus_hit = usb_ctrl_enabled && usb_bus_reset;
  assign vbus_hit = sync_q[S_VBUS] == vbus_polarity_select;

  // the reset pin is never driven high, only released
  assign rst_pin_out = 1'b0;
  assign sys_rst_n = state[0];
  assign exit_go = (state == RSQ_EXIT) && (next_state == RSQ_RUN);

  // every active reset cause, one bit per flag position
  always_comb begin
    raw = 8'h00;
    raw[B_PIN] = !sync_q[S_PIN] && rst_pin_oe_n;
    raw[B_POR] = (vdd_sel && vdd_mon_en && !sync_q[S_VDD]) ||
                 soft_por;
    raw[B_MCD] = mcd_en && sync_q[S_MCD];
    raw[B_WDT] = wdt_timeout;
    raw[B_SW] = sw_req;
    raw[B_CMP] = cmp_en && !sync_q[S_CMP];
    raw[B_FERR] = flash_err;
    raw[B_USB] = usb_en && (usb_bus_hit || vbus_hit);
  end

  // sequencer: run, hold reset, wait for the pin to read high
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cause = cause;
    unique case (state)
      RSQ_RUN: begin
        if (|raw) begin
          next_state = RSQ_HOLD;
          next_cnt = HOLD_LOAD;
          next_cause = pick_cause(raw);
        end
      end
      RSQ_HOLD: begin
        if (|raw) begin
          next_cnt = HOLD_LOAD;
        end else if (cnt == 5'h00) begin
          next_state = RSQ_EXIT;
        end else begin
          next_cnt = 5'(cnt - 5'h01);
        end
      end
      RSQ_EXIT: begin
        if (sync_q[S_PIN]) begin
          next_state = RSQ_RUN;
        end
      end
      default: begin
        next_state = RSQ_HOLD;
        next_cnt = HOLD_LOAD;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RSQ_RUN;
      cnt <= 5'h00;
      cause <= FLAGS_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cause <= next_cause;
    end
  end

  // only a power cause pulls the pin, from the supply or the soft_por write; other internal causes leave it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_oe_n <= 1'b1;
    end else begin
      rst_pin_oe_n <= !((next_state == RSQ_HOLD) &&
                        next_cause[B_POR]);
    end
  end

  // cause flags: replaced by the one-hot cause on reset exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAGS_RST;
    end else if (exit_go) begin
      flags <= cause;
    end
  end

  // source enables survive every reset the block itself makes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_en <= EN_RST[B_USB];
      cmp_en <= EN_RST[B_CMP];
      mcd_en <= EN_RST[B_MCD];
      vdd_sel <= EN_RST[B_POR];
    end else if (wr_rcr) begin
      usb_en <= pwdata[B_USB];
      cmp_en <= pwdata[B_CMP];
      mcd_en <= pwdata[B_MCD];
      vdd_sel <= pwdata[B_POR];
    end
  end

  // sticky status: a set on exit beats a one written to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist <= 8'h00;
    end else begin
      ist <= (ist & ~(wr_ist ? pwdata[7:0] : 8'h00)) |
             (exit_go ? cause : 8'h00);
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imk <= MASK_RST;
    end else if (wr_imk) begin
      imk <= pwdata[7:0];
    end
  end

  assign irq = |(ist & imk);

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        RCR_ADDR: prdata <= {24'h00_0000, flags};
        IST_ADDR: prdata <= {24'h00_0000, ist};
        IMK_ADDR: prdata <= {24'h00_0000, imk};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ferr_flag_a: assert property (
    exit_go && cause[B_FERR] |=> flags[B_FERR] && $onehot(flags))
    else $error("flash error flag not set alone");
  pin_quiet_a: assert property (
    !rst_pin_oe_n |-> cause[B_POR] && (state == RSQ_HOLD))
    else $error("reset pin pulled for an internal cause");
  sw_force_a: assert property (
    (state == RSQ_RUN) && wr_rcr && pwdata[B_SW] |=> !sys_rst_n [*3])
    else $error("software reset not forced");
  sw_quiet_a: assert property (
    (state == RSQ_RUN) && !(|raw) |=> sys_rst_n)
    else $error("reset without a cause");
  sw_flag_a: assert property (
    exit_go && cause[B_SW] |=> flags[B_SW] && !flags[B_USB])
    else $error("software flag wrong after exit");
  usb_en_a: assert property (
    wr_rcr |=> usb_en == $past(pwdata[B_USB]))
    else $error("usb enable not written");
  usb_bus_a: assert property (
    (state == RSQ_RUN) && usb_en && usb_ctrl_enabled && usb_bus_reset
    |=> !sys_rst_n) else $error("usb bus reset ignored");
  vbus_rst_a: assert property (
    (state == RSQ_RUN) && usb_en &&
    (sync_q[S_VBUS] == vbus_polarity_select) |=> !sys_rst_n)
    else $error("vbus reset ignored");
  usb_flag_a: assert property (
    exit_go && cause[B_USB] |=> flags == 8'h80)
    else $error("usb flag wrong after exit");
  wdt_flag_a: assert property (
    $rose(flags[B_WDT]) |-> $past(cause[B_WDT]) && $past(exit_go))
    else $error("watchdog flag without watchdog cause");
  por_flag_a: assert property (
    $rose(flags[B_POR]) |-> $past(cause[B_POR]))
    else $error("power flag without power cause");
  mcd_en_a: assert property (
    wr_rcr |=> mcd_en == $past(pwdata[B_MCD]))
    else $error("clock-loss enable not written");
  pin_flag_a: assert property (
    exit_go && cause[B_PIN] |=> flags == 8'h01)
    else $error("pin flag wrong after exit");
  cmp_rst_a: assert property (
    (state == RSQ_RUN) && cmp_en && !sync_q[S_CMP] |=> !sys_rst_n)
    else $error("comparator reset ignored");
  flag_exit_a: assert property (
    exit_go |=> flags == $past(cause) && $onehot(flags))
    else $error("flags not replaced on exit");
  hold_len_a: assert property (
    $fell(sys_rst_n) |-> !sys_rst_n [*8])
    else $error("reset held too briefly");
endmodule : rsq_reset_source
`default_nettype wire

// >>> inc/rsq_pkg.sv
// constants, types and helpers for the reset-cause sequencer
`default_nettype none
package rsq_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] RCR_IDX = 12'h0EF;
  localparam logic [11:0] IST_IDX = 12'h0F0;
  localparam logic [11:0] IMK_IDX = 12'h0F1;
  localparam logic [11:0] RCR_ADDR = RCR_IDX << 2;
  localparam logic [11:0] IST_ADDR = IST_IDX << 2;
  localparam logic [11:0] IMK_ADDR = IMK_IDX << 2;

  // bit positions in the cause register, status and mask
  localparam int B_PIN = 0;
  localparam int B_POR = 1;
  localparam int B_MCD = 2;
  localparam int B_WDT = 3;
  localparam int B_SW = 4;
  localparam int B_CMP = 5;
  localparam int B_FERR = 6;
  localparam int B_USB = 7;

  // positions in the synchronised pin vector
  localparam int S_PIN = 0;
  localparam int S_VDD = 1;
  localparam int S_MCD = 2;
  localparam int S_CMP = 3;
  localparam int S_VBUS = 4;

  // values after power-on
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [4:0] SYNC_RST = 5'h0B;

  // last byte of user code space
  localparam logic [15:0] CODE_TOP = 16'h3DFF;

  // least time the system reset is held for an internal cause
  localparam int HOLD_NS = 1000;
  localparam int CLK_KHZ = 25000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [4:0] HOLD_LOAD = 5'(HOLD_CYC - 1);

  typedef enum logic [2:0] {
    RSQ_RUN = 3'b001,
    RSQ_HOLD = 3'b010,
    RSQ_EXIT = 3'b100
  } rsq_state_e;

  // one cycle of flash traffic seen by the access checker
  typedef struct packed {
    logic xwr;
    logic [15:0] xaddr;
    logic cread;
    logic [15:0] caddr;
    logic fetch;
    logic [15:0] faddr;
    logic sec_viol;
    logic wr_erase;
  } rsq_flash_req_s;

  function automatic logic above_top(input logic [15:0] a);
    return a > CODE_TOP;
  endfunction : above_top

  // lowest set bit wins: pin, power, clock loss, watchdog, ...
  function automatic logic [7:0] pick_cause(input logic [7:0] raw);
    return raw & (~raw + 8'h01);
  endfunction : pick_cause

endpackage : rsq_pkg
`default_nettype wire

// >>> hw/rsq_sync.sv
// three-stage synchroniser for inputs from outside the clock domain
`default_nettype none
module rsq_sync import rsq_pkg::*; #(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 is read by s2 only; a bit moves once s2 and s3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      dout <= RST;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : rsq_sync
`default_nettype wire

// >>> hw/rsq_flash_chk.sv
// illegal flash access detector feeding the reset sequencer
`default_nettype none
module rsq_flash_chk import rsq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire rsq_flash_req_s flash_req,
  input wire logic flash_write_enable,
  input wire logic vdd_mon_en,
  output logic flash_err
);
  logic next_err;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // any forbidden access raises the error
  always_comb begin
    next_err = 1'b0;
    if (flash_req.xwr && flash_write_enable &&
        above_top(flash_req.xaddr)) begin
      next_err = 1'b1;
    end
    if (flash_req.cread && above_top(flash_req.caddr)) begin
      next_err = 1'b1;
    end
    if (flash_req.fetch && above_top(flash_req.faddr)) begin
      next_err = 1'b1;
    end
    if (flash_req.sec_viol) begin
      next_err = 1'b1;
    end
    if (flash_req.wr_erase && !vdd_mon_en) begin
      next_err = 1'b1;
    end
  end

  // one-cycle error pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_err <= 1'b0;
    end else begin
      flash_err <= next_err;
    end
  end

  flash_wr_a: assert property (
    flash_req.xwr && flash_write_enable && flash_req.xaddr > CODE_TOP
    |=> flash_err) else $error("flash write above top not caught");
  code_rd_a: assert property (
    flash_req.cread && flash_req.caddr > CODE_TOP |=> flash_err)
    else $error("code read above top not caught");
  fetch_top_a: assert property (
    flash_req.fetch && flash_req.faddr > CODE_TOP |=> flash_err)
    else $error("branch above top not caught");
  sec_viol_a: assert property (
    flash_req.sec_viol |=> flash_err)
    else $error("security violation not caught");
  wr_novdd_a: assert property (
    flash_req.wr_erase && !vdd_mon_en |=> flash_err)
    else $error("write without supply monitor not caught");
endmodule : rsq_flash_chk
`default_nettype wire

// >>> tb/rsq_far.sv
// far-side model: core, flash access path and usb controller events
`default_nettype none
module rsq_far import rsq_pkg::*; (
  input wire logic pclk,
  input wire logic [3:0] kind,
  input wire logic go,
  input wire logic [1:0] dly,
  input wire logic [15:0] addr,
  input wire logic pol,
  output rsq_flash_req_s flash_req,
  output logic flash_write_enable,
  output logic vdd_mon_en,
  output logic usb_ctrl_enabled,
  output logic usb_bus_reset,
  output logic wdt_timeout,
  output logic vbus_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_cnt = 3'h0;
  logic [3:0] act = 4'h0;
  logic [15:0] a = 16'h0;
  logic fire;
  logic [1:0] vb_cnt = 2'h0;
  // event fires one cycle, after a prompt or slow delay
  always @(posedge pclk) begin
    if (go) begin
      wait_cnt <= {1'b0, dly} + 3'h1;
      act <= kind;
      a <= addr;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end
  assign fire = wait_cnt == 3'h1;
  // vbus match lasts three cycles so the pin synchroniser passes it
  always @(posedge pclk) begin
    if (fire && act == 4'h8) begin
      vb_cnt <= 2'h2;
    end else if (vb_cnt != 2'h0) begin
      vb_cnt <= vb_cnt - 2'h1;
    end
  end
  // idle address lines show the inverse of the last address
  always_comb begin
    flash_req = '0;
    flash_req.xaddr = ~a;
    flash_req.caddr = ~a;
    flash_req.faddr = ~a;
    case (act)
      4'h1, 4'h9: begin
        flash_req.xwr = fire;
        flash_req.xaddr = a;
      end
      4'h2: begin
        flash_req.cread = fire;
        flash_req.caddr = a;
      end
      4'h3: begin
        flash_req.fetch = fire;
        flash_req.faddr = a;
      end
      4'h4: flash_req.sec_viol = fire;
      4'h5: flash_req.wr_erase = fire;
      default: ;
    endcase
    flash_write_enable = act == 4'h1;
    vdd_mon_en = act != 4'h5;
    usb_ctrl_enabled = 1'b1;
    usb_bus_reset = fire && act == 4'h6;
    wdt_timeout = fire && act == 4'h7;
    vbus_pin = (act == 4'h8 && (fire || vb_cnt != 2'h0)) ?
               pol : ~pol;
  end
endmodule : rsq_far
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the reset-cause sequencer
`default_nettype none
module testbench import rsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  rsq_flash_req_s flash_req;
  logic fwe, vmon, usb_en, usb_rst, wdt, vbus, pol, go;
  logic pin_out, pin_oe_n, sys_rst_n, irq;
  logic cmp0, mcd, rstn_pin;
  logic [3:0] kind;
  logic [1:0] dly;
  logic [15:0] addr;
  logic [7:0] expq[$];
  int failures = 0;
  int samples_checked = 0;
  rsq_reset_source uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_req(flash_req), .flash_write_enable(fwe), .vdd_mon_en(vmon),
    .vdd_ok_pin(1'b1), .clock_loss_pin(mcd), .cmp0_pin(cmp0),
    .wdt_timeout(wdt), .usb_ctrl_enabled(usb_en), .usb_bus_reset(usb_rst),
    .vbus_pin(vbus), .vbus_polarity_select(pol), .rst_pin_in_n(rstn_pin),
    .rst_pin_out(pin_out), .rst_pin_oe_n(pin_oe_n), .sys_rst_n(sys_rst_n),
    .irq(irq));
  rsq_far far (.pclk(pclk), .kind(kind), .go(go), .dly(dly), .addr(addr),
    .pol(pol), .flash_req(flash_req), .flash_write_enable(fwe),
    .vdd_mon_en(vmon), .usb_ctrl_enabled(usb_en), .usb_bus_reset(usb_rst),
    .wdt_timeout(wdt), .vbus_pin(vbus));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // one apb transfer; a read notes its expected byte first
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    if (!w) expq.push_back(d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // read watcher takes the oldest note off the queue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      chk("read data", expq.pop_front(), prdata[7:0]);
  end
  // waits for a system reset or its absence, pin never driven
  task automatic see_reset(input logic exp, input string nm);
    int n;
    logic fired, drove;
    fired = 1'b0;
    drove = 1'b0;
    for (n = 0; n < 40 && !fired; n++) begin
      @(posedge pclk);
      fired = sys_rst_n === 1'b0;
    end
    chk(nm, {7'h0, exp}, {7'h0, fired});
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
      drove |= pin_oe_n !== 1'b1;
    end
    chk("pin drive", 8'h00, {7'h0, drove});
  endtask : see_reset
  task automatic ev(input logic [3:0] k, input logic [15:0] ad);
    kind <= k;
    addr <= ad;
    dly <= 2'($urandom_range(3, 0));
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask : ev
  // three-cycle pulse on reset pin, comparator or clock-loss input
  task automatic pin_pulse(input logic [2:0] m);
    {rstn_pin, cmp0, mcd} <= {~m[2], ~m[1], m[0]};
    repeat (3) @(posedge pclk);
    {rstn_pin, cmp0, mcd} <= 3'b110;
  endtask : pin_pulse
  // hang guard
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, go, pol, presetn} = 6'h00;
    {rstn_pin, cmp0, mcd} = 3'b110;
    {paddr, pwdata, kind, dly, addr} = '0;
    void'($urandom(37270));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RCR_ADDR, FLAGS_RST);
    apb(1'b0, IST_ADDR, 8'h00);
    apb(1'b0, IMK_ADDR, MASK_RST);
    apb(1'b0, 12'h004, 8'h00);
    chk("slverr", 8'h01, {7'h0, last_err});
    apb(1'b1, RCR_ADDR, 8'h6C);
    see_reset(1'b0, "enable write");
    apb(1'b1, RCR_ADDR, 8'h00);
    see_reset(1'b0, "zero force");
    apb(1'b1, RCR_ADDR, 8'h10);
    see_reset(1'b1, "sw reset");
    apb(1'b0, RCR_ADDR, 8'h10);
    chk("irq masked", 8'h00, {7'h0, irq});
    apb(1'b1, IMK_ADDR, 8'h10);
    chk("irq raised", 8'h01, {7'h0, irq});
    apb(1'b1, IST_ADDR, 8'h10);
    chk("irq cleared", 8'h00, {7'h0, irq});
    apb(1'b0, IST_ADDR, 8'h00);
    for (int k = 1; k <= 5; k++) begin
      ev(4'(k), 16'h3E00 + 16'($urandom_range(255, 0)));
      see_reset(1'b1, "flash error");
      apb(1'b0, RCR_ADDR, 8'h40);
    end
    for (int i = 0; i < 7; i++) begin
      ev(i == 6 ? 4'h9 : 4'(1 + i % 3),
         i < 3 ? CODE_TOP : i == 6 ? 16'hFFFF :
         16'($urandom_range(16'h3DFF, 0)));
      see_reset(1'b0, "legal access");
    end
    ev(4'h7, 16'h0);
    see_reset(1'b1, "watchdog");
    apb(1'b0, RCR_ADDR, 8'h08);
    ev(4'h6, 16'h0);
    see_reset(1'b0, "usb disabled");
    apb(1'b1, RCR_ADDR, 8'h80);
    ev(4'h6, 16'h0);
    see_reset(1'b1, "usb bus reset");
    apb(1'b0, RCR_ADDR, 8'h80);
    for (int p = 1; p >= 0; p--) begin
      apb(1'b1, RCR_ADDR, 8'h00);
      pol <= 1'(p);
      repeat (5) @(posedge pclk);
      apb(1'b1, RCR_ADDR, 8'h80);
      ev(4'h8, 16'h0);
      see_reset(1'b1, "vbus match");
      apb(1'b0, RCR_ADDR, 8'h80);
    end
    apb(1'b1, RCR_ADDR, 8'h20);
    pin_pulse(3'b010);
    see_reset(1'b1, "comparator");
    apb(1'b0, RCR_ADDR, 8'h20);
    apb(1'b1, RCR_ADDR, 8'h04);
    pin_pulse(3'b001);
    see_reset(1'b1, "clock loss");
    apb(1'b0, RCR_ADDR, 8'h04);
    apb(1'b1, RCR_ADDR, 8'h00);
    pin_pulse(3'b001);
    see_reset(1'b0, "clock loss off");
    pin_pulse(3'b100);
    see_reset(1'b1, "reset pin");
    apb(1'b0, RCR_ADDR, 8'h01);
    chk("pin level", 8'h00, {7'h0, pin_out});
    complete_run();
  end
endmodule : testbench
`default_nettype wire
